// file: common/aout_pkg.sv
// Purpose: Constants and types for the analog output channel control.
// Assumes: pclk at 10 MHz, APB with 32-bit data, one word per register.
// Notes: Signal levels are signed 16-bit, in uA for current, mV for voltage.
`default_nettype none
package aout_pkg;
  localparam int CLK_MHZ        = 10;
  localparam int WDT_TIMEOUT_US = 100000;

  localparam logic [7:0] A_CFG  = 8'h00;
  localparam logic [7:0] A_ELO  = 8'h04;
  localparam logic [7:0] A_EHI  = 8'h08;
  localparam logic [7:0] A_ULO  = 8'h0c;
  localparam logic [7:0] A_UHI  = 8'h10;
  localparam logic [7:0] A_FVAL = 8'h14;
  localparam logic [7:0] A_CMD  = 8'h18;
  localparam logic [7:0] A_CTL  = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_LVL  = 8'h24;

  localparam int B_DIS = 0;
  localparam int B_ALE = 8;
  localparam int B_FM  = 9;
  localparam int C_UNL  = 0;
  localparam int C_EN   = 1;
  localparam int C_KICK = 2;
  localparam int S_UNDER = 0;
  localparam int S_OVER  = 1;
  localparam int S_LERR  = 2;
  localparam int S_CFGE  = 3;
  localparam int S_BAD   = 4;
  localparam int S_FLT   = 5;
  localparam int S_WDT   = 6;
  localparam int S_DRV   = 7;

  typedef logic signed [15:0] lvl_t;
  typedef struct packed { lvl_t lo; lvl_t hi; } span_t;
  typedef enum logic [2:0] {RG_0_20MA, RG_4_20MA, RG_0_5V, RG_0_10V,
                            RG_PM10V} range_t;
  typedef enum logic [1:0] {CL_RANGE, CL_LIMIT, CL_USER, CL_BAD} clamp_t;

  localparam lvl_t ENG_LO_RST = 16'h0000;
  localparam lvl_t ENG_HI_RST = 16'h4e20;
  localparam lvl_t LVL_MAX    = 16'h7fff;
  localparam lvl_t LVL_MIN    = 16'h8000;

  // Nominal span per range; an unknown code falls back to 0-20 mA.
  function automatic span_t range_span(input logic [2:0] r);
    case (r)
      RG_4_20MA: range_span = '{16'h0fa0, 16'h4e20};
      RG_0_5V:   range_span = '{16'h0000, 16'h1388};
      RG_0_10V:  range_span = '{16'h0000, 16'h2710};
      RG_PM10V:  range_span = '{16'hd8f0, 16'h2710};
      default:   range_span = '{16'h0000, 16'h4e20};
    endcase
  endfunction : range_span

  function automatic span_t limit_span(input logic [2:0] r);
    case (r)
      RG_4_20MA: limit_span = '{16'h0c80, 16'h5208};
      RG_0_5V:   limit_span = '{16'h0000, 16'h1482};
      RG_0_10V:  limit_span = '{16'h0000, 16'h2904};
      RG_PM10V:  limit_span = '{16'hd6fc, 16'h2904};
      default:   limit_span = '{16'h0000, 16'h5208};
    endcase
  endfunction : limit_span
endpackage : aout_pkg
`default_nettype wire

// file: rtl/aout_channel.sv
// Purpose: Setup decode, clamping, scaling and fault handling of one
//          analog output channel, with its registers on APB.
// Assumes: Fault and load error arrive asynchronously on pins.
// Notes: Registers answer with one wait state; outputs are registered.
`timescale 1ns/10ps
`default_nettype none
module aout_channel #(
  parameter int unsigned WDT_CYCLES =
    aout_pkg::WDT_TIMEOUT_US * aout_pkg::CLK_MHZ
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         fault_in,
  input  wire logic         load_err_in,
  output aout_pkg::lvl_t    level_out,
  output logic              drive_en,
  output logic              wdt_reset
);

  typedef struct packed {
    logic [15:0]    cfg;
    aout_pkg::lvl_t eng_lo_w;
    aout_pkg::lvl_t eng_hi_w;
    aout_pkg::lvl_t eng_lo;
    aout_pkg::lvl_t eng_hi;
    aout_pkg::lvl_t user_lo;
    aout_pkg::lvl_t user_hi;
    aout_pkg::lvl_t fault_val;
    aout_pkg::lvl_t cmd;
    aout_pkg::lvl_t level;
    logic           ctl_en;
    logic           drv;
    logic [1:0]     s1;
    logic [1:0]     s2;
    logic [1:0]     s3;
    logic [1:0]     pins;
    logic           under;
    logic           over;
    logic           lerr;
    logic           cfg_err;
    logic           bad;
    logic [31:0]    wdt_cnt;
    logic           wdt_fired;
    logic           wdt_rst;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
  } st_t;

  st_t r;
  st_t n;

  function automatic aout_pkg::lvl_t clip(input aout_pkg::lvl_t v,
                                          input aout_pkg::span_t s);
    if (v < s.lo) begin
      clip = s.lo;
    end else if (v > s.hi) begin
      clip = s.hi;
    end else begin
      clip = v;
    end
  endfunction : clip

  // Wide intermediate keeps the product exact; the result saturates.
  function automatic aout_pkg::lvl_t scale(input aout_pkg::lvl_t v,
                                           input aout_pkg::lvl_t elo,
                                           input aout_pkg::lvl_t ehi,
                                           input aout_pkg::span_t s);
    logic signed [39:0] num;
    logic signed [39:0] den;
    logic signed [39:0] q;
    num = (40'(v) - 40'(elo)) * (40'(s.hi) - 40'(s.lo));
    den = 40'(ehi) - 40'(elo);
    if (den <= 40'(16'sh0000)) begin
      den = 40'h0000000001;
    end
    q = num / den + 40'(s.lo);
    if (q > 40'(aout_pkg::LVL_MAX)) begin
      scale = aout_pkg::LVL_MAX;
    end else if (q < 40'(aout_pkg::LVL_MIN)) begin
      scale = aout_pkg::LVL_MIN;
    end else begin
      scale = q[15:0];
    end
  endfunction : scale

  logic [2:0]        rng;
  aout_pkg::clamp_t  lcl;
  aout_pkg::clamp_t  hcl;
  logic              dis;
  logic              ale;
  logic              fmode;
  aout_pkg::span_t   rs;
  aout_pkg::span_t   ls;
  aout_pkg::lvl_t    lo_th;
  aout_pkg::lvl_t    hi_th;
  aout_pkg::lvl_t    sig;
  aout_pkg::lvl_t    clamped;
  logic              under_c;
  logic              over_c;
  logic              flt;
  logic              lu;
  logic              hu;
  logic              cfg_err_c;
  logic              wr_go;
  logic              ctl_wr;
  logic              unl;
  logic              kick;
  logic              wdt_exp;

  assign dis   = r.cfg[aout_pkg::B_DIS];
  assign rng   = r.cfg[3:1];
  assign lcl   = aout_pkg::clamp_t'(r.cfg[5:4]);
  assign hcl   = aout_pkg::clamp_t'(r.cfg[7:6]);
  assign ale   = r.cfg[aout_pkg::B_ALE];
  assign fmode = r.cfg[aout_pkg::B_FM];
  assign rs    = aout_pkg::range_span(rng);
  assign ls    = aout_pkg::limit_span(rng);
  assign lu    = lcl == aout_pkg::CL_USER;
  assign hu    = hcl == aout_pkg::CL_USER;

  // A reserved clamp code behaves as the range value and is flagged.
  assign lo_th = (lcl == aout_pkg::CL_LIMIT) ? ls.lo :
                 lu ? clip(r.user_lo, ls) : rs.lo;
  assign hi_th = (hcl == aout_pkg::CL_LIMIT) ? ls.hi :
                 hu ? clip(r.user_hi, ls) : rs.hi;

  assign sig     = scale(r.cmd, r.eng_lo, r.eng_hi, rs);
  assign under_c = !dis && (sig <= lo_th);
  assign over_c  = !dis && (sig >= hi_th);
  assign clamped = (sig <= lo_th) ? lo_th :
                   (sig >= hi_th) ? hi_th : sig;

  // Range and reserved-code checks always run; each user-value check only runs while its field selects the user value.
  assign cfg_err_c =
    (rng > aout_pkg::RG_PM10V) ||
    (lcl == aout_pkg::CL_BAD) || (hcl == aout_pkg::CL_BAD) ||
    (lu && hu && !(r.user_hi > r.user_lo)) ||
    (lu && (r.user_lo < ls.lo || r.user_lo > ls.hi)) ||
    (hu && (r.user_hi < ls.lo || r.user_hi > ls.hi)) ||
    (hu && !(r.user_hi > ls.lo && r.user_hi >= rs.lo)) ||
    (lu && !hu && !(r.user_lo < hi_th));

  assign flt     = r.pins[0] || r.wdt_fired;
  assign wr_go   = psel && penable && pwrite && r.pready;
  assign ctl_wr  = wr_go && (paddr == aout_pkg::A_CTL);
  assign unl     = ctl_wr && pwdata[aout_pkg::C_UNL];
  assign kick    = ctl_wr && pwdata[aout_pkg::C_KICK];
  assign wdt_exp = !kick && (r.wdt_cnt == 32'(WDT_CYCLES - 1));

  always_comb begin
    n = r;
    n.wdt_rst = 1'h0;
    n.pready  = 1'h0;
    n.pslverr = 1'h0;
    n.s1 = {load_err_in, fault_in};
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < 2; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.pins[i] = r.s3[i];
      end
    end

    // First access cycle prepares the answer, the next one completes.
    if (psel && penable && !r.pready) begin
      n.pready = 1'h1;
      n.prdata = '0;
      unique case (paddr)
        aout_pkg::A_CFG:  n.prdata[15:0] = r.cfg;
        aout_pkg::A_ELO:  n.prdata[15:0] = r.eng_lo_w;
        aout_pkg::A_EHI:  n.prdata[15:0] = r.eng_hi_w;
        aout_pkg::A_ULO:  n.prdata[15:0] = r.user_lo;
        aout_pkg::A_UHI:  n.prdata[15:0] = r.user_hi;
        aout_pkg::A_FVAL: n.prdata[15:0] = r.fault_val;
        aout_pkg::A_CMD:  n.prdata[15:0] = r.cmd;
        aout_pkg::A_CTL:  n.prdata[aout_pkg::C_EN] = r.ctl_en;
        aout_pkg::A_STAT: begin
          n.prdata[aout_pkg::S_UNDER] = r.under;
          n.prdata[aout_pkg::S_OVER]  = r.over;
          n.prdata[aout_pkg::S_LERR]  = r.lerr;
          n.prdata[aout_pkg::S_CFGE]  = r.cfg_err;
          n.prdata[aout_pkg::S_BAD]   = r.bad;
          n.prdata[aout_pkg::S_FLT]   = flt;
          n.prdata[aout_pkg::S_WDT]   = r.wdt_fired;
          n.prdata[aout_pkg::S_DRV]   = r.drv;
        end
        aout_pkg::A_LVL:  n.prdata[15:0] = r.level;
        default:          n.pslverr = 1'h1;
      endcase
    end

    if (wr_go) begin
      unique case (paddr)
        aout_pkg::A_CFG:  n.cfg       = pwdata[15:0];
        aout_pkg::A_ELO:  n.eng_lo_w  = pwdata[15:0];
        aout_pkg::A_EHI:  n.eng_hi_w  = pwdata[15:0];
        aout_pkg::A_ULO:  n.user_lo   = pwdata[15:0];
        aout_pkg::A_UHI:  n.user_hi   = pwdata[15:0];
        aout_pkg::A_FVAL: n.fault_val = pwdata[15:0];
        aout_pkg::A_CMD:  n.cmd       = pwdata[15:0];
        aout_pkg::A_CTL:  n.ctl_en    = pwdata[aout_pkg::C_EN];
        default: begin
        end
      endcase
    end

    // A reversed or equal pair leaves the last good scaling in force.
    if (r.eng_lo_w < r.eng_hi_w) begin
      n.eng_lo = r.eng_lo_w;
      n.eng_hi = r.eng_hi_w;
      n.bad    = 1'h0;
    end else begin
      n.bad    = 1'h1;
    end
    n.cfg_err = cfg_err_c;

    // A fresh condition wins over a release in the same cycle.
    n.under = under_c || (ale && r.under && !unl);
    n.over  = over_c || (ale && r.over && !unl);
    n.lerr  = (!dis && r.pins[1]) || (ale && r.lerr && !unl);

    if (wdt_exp) begin
      n.level = '0;
    end else if (flt) begin
      n.level = fmode ? r.fault_val : r.level;
    end else begin
      n.level = clamped;
    end

    // The watchdog keeps firing each period until software kicks it.
    if (kick) begin
      n.wdt_cnt   = '0;
      n.wdt_fired = 1'h0;
    end else if (wdt_exp) begin
      n.wdt_cnt   = '0;
      n.wdt_fired = 1'h1;
      n.wdt_rst   = 1'h1;
      n.ctl_en    = 1'h0;
    end else begin
      n.wdt_cnt   = r.wdt_cnt + 32'h00000001;
    end
    n.drv = r.ctl_en && !dis && !r.wdt_fired;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.eng_lo_w <= aout_pkg::ENG_LO_RST;
      r.eng_hi_w <= aout_pkg::ENG_HI_RST;
      r.eng_lo   <= aout_pkg::ENG_LO_RST;
      r.eng_hi   <= aout_pkg::ENG_HI_RST;
    end else begin
      r <= n;
    end
  end

  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign level_out = r.level;
  assign drive_en  = r.drv;
  assign wdt_reset = r.wdt_rst;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_disable_drive:
    assert property (dis |=> !drive_en)
      else $error("drive stayed on with channel disabled");

  a_limit_thresh:
    assert property (hcl == aout_pkg::CL_LIMIT |-> hi_th == ls.hi)
      else $error("high limit threshold wrong");

  a_user_clip:
    assert property (lu |-> lo_th >= ls.lo && lo_th <= ls.hi)
      else $error("user low clamp not clipped");

  a_over_clamp:
    assert property (!flt && !wdt_exp && over_c && sig > lo_th
                     |=> level_out == $past(hi_th) && r.over)
      else $error("over-range not clamped or flagged");

  a_latch_keep:
    assert property (ale && r.under && !unl |=> r.under)
      else $error("latched under alarm lost");

  a_follow_clear:
    assert property (!ale && !under_c |=> !r.under)
      else $error("unlatched under alarm did not follow");

  a_alarm_release:
    assert property (unl && !over_c |=> !r.over)
      else $error("release did not clear over alarm");

  a_fault_hold:
    assert property (flt && !fmode && !wdt_exp |=> $stable(level_out))
      else $error("output moved during hold fault");

  a_fault_subst:
    assert property (flt && fmode && !wdt_exp
                     |=> level_out == $past(r.fault_val))
      else $error("fault substitute not driven");

  a_bad_scaling:
    assert property (r.eng_lo_w >= r.eng_hi_w
                     |=> r.bad && $stable(r.eng_lo) && $stable(r.eng_hi))
      else $error("reversed scaling accepted");

  a_user_pair:
    assert property (lu && hu && r.user_hi <= r.user_lo |=> r.cfg_err)
      else $error("user clamp pair error not flagged");

  a_enable_gate:
    assert property (!r.ctl_en |=> !drive_en)
      else $error("driver on without enable");

  sequence s_wdt_expire;
    wdt_exp;
  endsequence

  sequence s_outputs_reset;
    wdt_reset && level_out == '0 ##1 !drive_en;
  endsequence

  a_wdt_reset:
    assert property (s_wdt_expire |=> s_outputs_reset)
      else $error("watchdog expiry did not reset outputs");

endmodule : aout_channel
`default_nettype wire

// file: verification/analog_output_channel_control_test.sv
// Purpose: Self-checking bench for the analog output channel control.
// Assumes: Default scaling 0..20000 at start; watchdog shortened to WDT.
// Notes: Every scenario kicks the watchdog first, except the reset and watchdog ones.
`timescale 1ns/10ps
`default_nettype none
module analog_output_channel_control_test;
  localparam int WDT = 2000;
  localparam logic [15:0] MID [5] = '{16'h2710, 16'h2ee0, 16'h09c4,
                                      16'h1388, 16'h0000};
  localparam logic [15:0] BOT [5] = '{16'h0000, 16'h0fa0, 16'h0000,
                                      16'h0000, 16'hd8f0};
  logic           pclk;
  logic           presetn;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [7:0]     paddr;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic           fault_in;
  logic           load_err_in;
  aout_pkg::lvl_t level_out;
  logic           drive_en;
  logic           wdt_reset;
  int             fail_count;
  int             checks_done;
  int             cyc;
  aout_channel #(.WDT_CYCLES(WDT)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_in(fault_in), .load_err_in(load_err_in),
    .level_out(level_out), .drive_en(drive_en), .wdt_reset(wdt_reset));
  host_model host_u (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fault_in(fault_in),
    .load_err_in(load_err_in));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      stop_test();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task tk(input int n);
    repeat (n) @(posedge pclk);
  endtask : tk
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host_u.xfer(1'b1, a, d, q, e);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    host_u.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  task cf(input logic [31:0] d);
    wr(aout_pkg::A_CFG, d);
  endtask : cf
  task cm(input logic [31:0] d);
    wr(aout_pkg::A_CMD, d);
  endtask : cm
  task kick;
    wr(aout_pkg::A_CTL, 32'h6);
  endtask : kick
  task ex(input string n, input logic [15:0] l, input logic [7:0] s);
    logic [31:0] q;
    tk(6);
    chk(n, {16'h0, level_out}, {16'h0, l});
    rd(aout_pkg::A_STAT, q);
    chk(n, q, {24'h0, s});
  endtask : ex
  task sb(input string n, input int b, input logic e);
    logic [31:0] q;
    tk(3);
    rd(aout_pkg::A_STAT, q);
    chk(n, {31'h0, q[b]}, {31'h0, e});
  endtask : sb
  task t_reset;
    logic [31:0] q;
    logic        e;
    tk(10);
    chk("drv_rst", {31'h0, drive_en}, 32'h0);
    chk("lvl_rst", {16'h0, level_out}, 32'h0);
    rd(aout_pkg::A_CFG, q);
    chk("cfg_rst", q, 32'h0);
    rd(aout_pkg::A_EHI, q);
    chk("ehi_rst", q, 32'h4e20);
    host_u.xfer(1'b0, 8'h28, 32'h0, q, e);
    chk("unmapped", {31'h0, e}, 32'h1);
  endtask : t_reset
  task t_enable;
    kick;
    tk(3);
    chk("drv_on", {31'h0, drive_en}, 32'h1);
    cf(32'h1);
    tk(3);
    chk("drv_dis", {31'h0, drive_en}, 32'h0);
    cf(32'h0);
    tk(3);
    chk("drv_back", {31'h0, drive_en}, 32'h1);
  endtask : t_enable
  task t_range;
    kick;
    for (int r = 0; r < 5; r++) begin
      cf({28'h0, r[2:0], 1'b0});
      cm(32'h2710);
      ex("mid", MID[r], 8'h80);
      cm(32'h0);
      ex("bottom", BOT[r], 8'h81);
    end
    cf(32'ha);
    sb("range5", 3, 1'b1);
  endtask : t_range
  task t_clamp;
    kick;
    cf(32'h0);
    cm(32'h61a8);
    ex("hi_rng", 16'h4e20, 8'h82);
    cf(32'h40);
    ex("hi_lim", 16'h5208, 8'h82);
    wr(aout_pkg::A_UHI, 32'h3a98);
    cf(32'h80);
    ex("hi_usr", 16'h3a98, 8'h82);
    wr(aout_pkg::A_UHI, 32'h7530);
    ex("hi_clip", 16'h5208, 8'h8a);
    cf(32'h0);
    ex("hi_skip", 16'h4e20, 8'h82);
    cf(32'h12);
    cm(32'hf830);
    ex("lo_lim", 16'h0c80, 8'h81);
    cf(32'h2);
    ex("lo_rng", 16'h0fa0, 8'h81);
    cf(32'h20);
    wr(aout_pkg::A_ULO, 32'h0bb8);
    cm(32'h03e8);
    ex("lo_usr", 16'h0bb8, 8'h81);
    wr(aout_pkg::A_ULO, 32'hfe0c);
    cm(32'h0);
    ex("lo_clip", 16'h0000, 8'h89);
  endtask : t_clamp
  task t_check;
    kick;
    cf(32'ha0);
    wr(aout_pkg::A_ULO, 32'h1388);
    wr(aout_pkg::A_UHI, 32'h1388);
    sb("both_eq", 3, 1'b1);
    wr(aout_pkg::A_UHI, 32'h1770);
    sb("both_gt", 3, 1'b0);
    cf(32'h80);
    wr(aout_pkg::A_UHI, 32'h0);
    sb("hi_at_lo", 3, 1'b1);
    wr(aout_pkg::A_UHI, 32'h1);
    sb("hi_above", 3, 1'b0);
    cf(32'h20);
    wr(aout_pkg::A_ULO, 32'h4e20);
    sb("lo_top", 3, 1'b1);
    wr(aout_pkg::A_ULO, 32'h4e1f);
    sb("lo_below", 3, 1'b0);
    cf(32'h30);
    sb("lo_code3", 3, 1'b1);
  endtask : t_check
  task t_latch;
    kick;
    // Command first: a low command left over would latch under-range.
    cm(32'h61a8);
    cf(32'h100);
    host_u.pins(1'b0, 1'b1);
    ex("l_set", 16'h4e20, 8'h86);
    host_u.pins(1'b0, 1'b0);
    cm(32'h2710);
    ex("l_keep", 16'h2710, 8'h86);
    host_u.unlatch();
    ex("l_rel", 16'h2710, 8'h80);
    cf(32'h0);
    host_u.pins(1'b0, 1'b1);
    ex("f_on", 16'h2710, 8'h84);
    host_u.pins(1'b0, 1'b0);
    ex("f_off", 16'h2710, 8'h80);
  endtask : t_latch
  task t_fault;
    kick;
    cm(32'h1388);
    ex("run", 16'h1388, 8'h80);
    host_u.pins(1'b1, 1'b0);
    tk(6);
    cm(32'h2710);
    ex("hold", 16'h1388, 8'ha0);
    host_u.pins(1'b0, 1'b0);
    ex("resume", 16'h2710, 8'h80);
    wr(aout_pkg::A_FVAL, 32'h1b58);
    cf(32'h200);
    host_u.pins(1'b1, 1'b0);
    tk(6);
    cm(32'h1388);
    ex("subst", 16'h1b58, 8'ha0);
    host_u.pins(1'b0, 1'b0);
    ex("back", 16'h1388, 8'h80);
  endtask : t_fault
  task t_scale;
    kick;
    cf(32'h0);
    cm(32'h2710);
    wr(aout_pkg::A_ELO, 32'h4e20);
    ex("bad_pair", 16'h2710, 8'h90);
    wr(aout_pkg::A_EHI, 32'h2ee0);
    wr(aout_pkg::A_ELO, 32'h07d0);
    cm(32'h1b58);
    ex("rescale", 16'h2710, 8'h80);
  endtask : t_scale
  task t_wdt;
    int n;
    n = 0;
    while (wdt_reset !== 1'b1 && n < 2 * WDT) begin
      @(posedge pclk);
      n++;
    end
    chk("wdt_fire", {31'h0, wdt_reset}, 32'h1);
    tk(4);
    chk("wdt_drv", {31'h0, drive_en}, 32'h0);
    chk("wdt_lvl", {16'h0, level_out}, 32'h0);
    n = 0;
    while (wdt_reset !== 1'b1 && n < WDT + 10) begin
      @(posedge pclk);
      n++;
    end
    chk("wdt_again", {31'h0, wdt_reset}, 32'h1);
    kick;
    sb("wdt_clear", 6, 1'b0);
    chk("wdt_drv_on", {31'h0, drive_en}, 32'h1);
  endtask : t_wdt
  initial begin
    presetn = 1'b0;
    fail_count = 0;
    checks_done = 0;
    cyc = 0;
    tk(20);
    presetn <= 1'b1;
    t_reset();
    t_enable();
    t_range();
    t_clamp();
    t_check();
    t_latch();
    t_fault();
    t_scale();
    t_wdt();
    stop_test();
  end
endmodule : analog_output_channel_control_test
`default_nettype wire

// file: verification/host_model.sv
// Purpose: Backplane host model: APB master plus fault and load pins.
// Assumes: One pclk domain; every signal changes just after a rising edge.
// Notes: A request is held until pready is seen high at a rising edge.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             fault_in,
  output logic             load_err_in
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fault_in = 1'b0;
    load_err_in = 1'b0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data is inverted so a stale value cannot pass as valid.
    pwdata <= ~d;
  endtask : xfer
  task pins(input logic f, input logic l);
    @(posedge pclk);
    fault_in <= f;
    load_err_in <= l;
  endtask : pins
  task unlatch;
    logic [31:0] q;
    logic        e;
    xfer(1'b1, aout_pkg::A_CTL, 32'h7, q, e);
  endtask : unlatch
endmodule : host_model
`default_nettype wire
